/* ulc_pkg.sv */
package ulc_pkg;

  // register word addresses on the avalon word bus
  localparam logic [3:0] ULC_ADDR_DATA  = 4'h0;
  localparam logic [3:0] ULC_ADDR_STAT  = 4'h1;
  localparam logic [3:0] ULC_ADDR_IBRD  = 4'h2;
  localparam logic [3:0] ULC_ADDR_FBRD  = 4'h3;
  localparam logic [3:0] ULC_ADDR_LINE  = 4'h4;
  localparam logic [3:0] ULC_ADDR_CTRL  = 4'h5;

  // line_control field positions
  localparam int ULC_LC_HOLD_LOW = 0;
  localparam int ULC_LC_PARITY   = 1;
  localparam int ULC_LC_POLARITY = 2;
  localparam int ULC_LC_TWO_STOP = 3;
  localparam int ULC_LC_QUEUE    = 4;
  localparam int ULC_LC_WORD_LENGTH_SEL_LO  = 5;
  localparam int ULC_LC_STICK    = 7;

  // port_control field positions
  localparam int ULC_PC_MASTER   = 0;
  localparam int ULC_PC_LOOPBACK = 7;
  localparam int ULC_PC_TX_ON    = 8;
  localparam int ULC_PC_RX_ON    = 9;
  localparam int ULC_PC_RTS      = 11;
  localparam int ULC_PC_RTS_FLOW = 14;
  localparam int ULC_PC_CTS_FLOW = 15;

  // reset values and control write mask
  localparam logic [7:0]  ULC_LINE_RST = 8'h00;
  localparam logic [15:0] ULC_CTRL_RST = 16'h0300;
  localparam logic [15:0] ULC_CTRL_WMASK = 16'hcb81;
  localparam logic [15:0] ULC_IBRD_RST = 16'h0001;
  localparam logic [5:0]  ULC_FBRD_RST = 6'h00;

  // oversampling factor and queue depth
  localparam int ULC_OVERSAMPLE = 16;
  localparam int ULC_QDEPTH     = 16;

  typedef enum logic [4:0] {
    ULC_S_IDLE   = 5'b00001,
    ULC_S_START  = 5'b00010,
    ULC_S_DATA   = 5'b00100,
    ULC_S_PARITY = 5'b01000,
    ULC_S_STOP   = 5'b10000
  } ulc_state_t;

  // avalon request carrier
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } ulc_req_t;

endpackage

/* ulc_uart.sv */
`timescale 1ns/1ps
// What this block does
// - stick parity sends and checks constant: 1 if polarity 0, else 0
// - word length field selects five to eight data bits both ways
// - queue enable off gives one-byte holding registers, on gives full queues
// - two-stop select appends two stop bits on transmit
// - receiver checks only the first stop bit
// - parity polarity selects odd when 0, even when 1
// - parity off means no parity bit sent or checked
// - hold-low bit drives line low after current character finishes
// - transmit needs master enable and transmit enable
// - receive needs master enable and receive enable
// - clearing queue enable flushes the transmit queue
// - clear-to-send flow control starts frames only while input is low
// - request flow control requests data only while receive queue has room
// - request-to-send bit drives active-low output as its complement
// - receive enable resets to 1; current character completes on disable
// - transmit enable resets to 1; current character completes on disable
// - loopback feeds transmit to receive and modem outputs to inputs
// - master disable stops only after the current characters complete
// - unimplemented control bits read as zero and are written as zero
// - bit timing is reference clock over sixteen times baud, int plus frac
module ulc_uart #(
  parameter int QDEPTH = ulc_pkg::ULC_QDEPTH
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // serial line and handshake
  input  wire logic        serial_in_line_in,
  output logic             serial_out_line_out,
  input  wire logic        clear_to_send_n_in,
  output logic             request_to_send_n_out
);
  import ulc_pkg::*;

  localparam int QW = $clog2(QDEPTH);

  ulc_req_t req;
  assign req = '{avs_address_in, avs_read_in, avs_write_in, avs_writedata_in};

  // registers
  logic [7:0]  line_reg, line_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] ibrd_reg, ibrd_next;
  logic [5:0]  fbrd_reg, fbrd_next;
  logic        ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;

  // transmit queue
  logic [7:0]  txq [QDEPTH];
  logic [QW:0] tx_wp_reg, tx_wp_next, tx_rp_reg, tx_rp_next;
  // receive queue
  logic [7:0]  rxq [QDEPTH];
  logic [QW:0] rx_wp_reg, rx_wp_next, rx_rp_reg, rx_rp_next;

  logic [QW:0] tx_cnt, rx_cnt, cap;
  logic        tx_full, tx_empty, rx_full, rx_empty;
  logic        tx_push, tx_pop, rx_push, rx_pop;

  // capacity is one word in character mode
  assign cap      = line_reg[ULC_LC_QUEUE] ? (QW+1)'(QDEPTH) : (QW+1)'(1);
  assign tx_cnt   = tx_wp_reg - tx_rp_reg;
  assign rx_cnt   = rx_wp_reg - rx_rp_reg;
  assign tx_full  = tx_cnt >= cap;
  assign tx_empty = tx_cnt == '0;
  assign rx_full  = rx_cnt >= cap;
  assign rx_empty = rx_cnt == '0;

  // fractional baud tick: 16x rate, accumulate divisor in 1/64 units
  logic [21:0] bacc_reg, bacc_next;
  logic        tick;
  logic [21:0] bdiv;
  assign bdiv = {ibrd_reg, fbrd_reg};
  always_comb begin
    tick      = 1'b0;
    bacc_next = bacc_reg + 22'h000040;
    if (bacc_next >= bdiv) begin
      tick      = 1'b1;
      bacc_next = bacc_next - bdiv;
    end
  end

  // shared frame helpers
  function automatic logic [3:0] data_bits(input logic [1:0] wl);
    data_bits = 4'(5 + 32'(wl));
  endfunction
  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lc);
    logic [7:0] used;
    // bits above the word length must not count toward parity
    used = 8'hff >> (4'h8 - data_bits(lc[6:5]));
    if (lc[ULC_LC_STICK])
      par_bit = ~lc[ULC_LC_POLARITY];
    else
      par_bit = (^(d & used)) ^ ~lc[ULC_LC_POLARITY];
  endfunction

  logic       tx_go, rx_go;
  assign tx_go = ctrl_reg[ULC_PC_MASTER] & ctrl_reg[ULC_PC_TX_ON];
  assign rx_go = ctrl_reg[ULC_PC_MASTER] & ctrl_reg[ULC_PC_RX_ON];

  // loopback muxing
  logic tx_line, rx_line, cts_n_eff, rts_n;
  assign rx_line   = ctrl_reg[ULC_PC_LOOPBACK] ? tx_line : serial_in_line_in;
  assign cts_n_eff = ctrl_reg[ULC_PC_LOOPBACK] ? rts_n : clear_to_send_n_in;

  // transmitter
  ulc_state_t tx_st_reg, tx_st_next;
  logic [3:0] tx_sub_reg, tx_sub_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic       tx_par_reg, tx_par_next;
  logic       tx_ln_reg, tx_ln_next;
  logic       cts_ok;
  assign cts_ok = ~ctrl_reg[ULC_PC_CTS_FLOW] | ~cts_n_eff;
  always_comb begin
    tx_st_next  = tx_st_reg;
    tx_sub_next = tx_sub_reg;
    tx_bit_next = tx_bit_reg;
    tx_sh_next  = tx_sh_reg;
    tx_par_next = tx_par_reg;
    tx_ln_next  = tx_ln_reg;
    tx_pop      = 1'b0;
    if (tick) begin
      tx_sub_next = tx_sub_reg + 4'h1;
      unique case (tx_st_reg)
        ULC_S_IDLE: begin
          tx_sub_next = 4'h0;
          // idle line high unless break held; break waits for frame end
          tx_ln_next  = ~line_reg[ULC_LC_HOLD_LOW];
          if (tx_go && !tx_empty && cts_ok && !line_reg[ULC_LC_HOLD_LOW]) begin
            tx_pop      = 1'b1;
            tx_sh_next  = txq[tx_rp_reg[QW-1:0]];
            tx_par_next = par_bit(txq[tx_rp_reg[QW-1:0]], line_reg);
            tx_st_next  = ULC_S_START;
            tx_ln_next  = 1'b0;
          end
        end
        ULC_S_START:
          if (tx_sub_reg == 4'hf) begin
            tx_st_next  = ULC_S_DATA;
            tx_bit_next = 4'h0;
            tx_ln_next  = tx_sh_reg[0];
          end
        ULC_S_DATA:
          if (tx_sub_reg == 4'hf) begin
            tx_sh_next  = tx_sh_reg >> 1;
            tx_bit_next = tx_bit_reg + 4'h1;
            tx_ln_next  = tx_sh_reg[1];
            if (tx_bit_reg == data_bits(line_reg[6:5]) - 4'h1) begin
              tx_st_next = line_reg[ULC_LC_PARITY] ? ULC_S_PARITY : ULC_S_STOP;
              tx_ln_next = line_reg[ULC_LC_PARITY] ? tx_par_reg : 1'b1;
              tx_bit_next = 4'h0;
            end
          end
        ULC_S_PARITY:
          if (tx_sub_reg == 4'hf) begin
            tx_st_next = ULC_S_STOP;
            tx_ln_next = 1'b1;
          end
        ULC_S_STOP: begin
          if (tx_sub_reg == 4'hf) tx_bit_next = tx_bit_reg + 4'h1;
          // last stop leaves one tick early: the idle tick completes its sixteen
          // enables are not looked at here so the frame always ends
          if (tx_sub_reg == 4'he && (tx_bit_reg != 4'h0 || !line_reg[ULC_LC_TWO_STOP])) begin
            tx_st_next = ULC_S_IDLE;
          end
        end
        default: tx_st_next = ULC_S_IDLE;
      endcase
    end
  end
  assign tx_line = tx_ln_reg;

  // receiver, sampling at the 16x tick: start bit checked at sub count 7, later bits mid-bit at sub count 15
  ulc_state_t rx_st_reg, rx_st_next;
  logic [3:0] rx_sub_reg, rx_sub_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic       rx_pe_reg, rx_pe_next, rx_fe_reg, rx_fe_next;
  logic [7:0] rx_word;
  always_comb begin
    rx_st_next  = rx_st_reg;
    rx_sub_next = rx_sub_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next  = rx_sh_reg;
    rx_pe_next  = rx_pe_reg;
    rx_fe_next  = rx_fe_reg;
    rx_push     = 1'b0;
    rx_word     = rx_sh_reg >> (4'h8 - data_bits(line_reg[6:5]));
    if (tick) begin
      rx_sub_next = rx_sub_reg + 4'h1;
      unique case (rx_st_reg)
        ULC_S_IDLE: begin
          rx_sub_next = 4'h0;
          if (rx_go && !rx_line) rx_st_next = ULC_S_START;
        end
        ULC_S_START:
          if (rx_sub_reg == 4'h7) begin
            rx_sub_next = 4'h0;
            rx_bit_next = 4'h0;
            rx_pe_next  = 1'b0; // no stale parity error on a frame without parity
            rx_st_next  = rx_line ? ULC_S_IDLE : ULC_S_DATA;
          end
        ULC_S_DATA:
          if (rx_sub_reg == 4'hf) begin
            rx_sh_next  = {rx_line, rx_sh_reg[7:1]};
            rx_bit_next = rx_bit_reg + 4'h1;
            if (rx_bit_reg == data_bits(line_reg[6:5]) - 4'h1)
              rx_st_next = line_reg[ULC_LC_PARITY] ? ULC_S_PARITY : ULC_S_STOP;
          end
        ULC_S_PARITY:
          if (rx_sub_reg == 4'hf) begin
            rx_pe_next = rx_line != par_bit(rx_word, line_reg);
            rx_st_next = ULC_S_STOP;
          end
        ULC_S_STOP:
          if (rx_sub_reg == 4'hf) begin
            // only the first stop bit is judged
            rx_fe_next = ~rx_line;
            rx_push    = 1'b1;
            rx_st_next = ULC_S_IDLE;
          end
        default: rx_st_next = ULC_S_IDLE;
      endcase
    end
  end

  // request-to-send: flow control overrides the software bit
  assign rts_n = ctrl_reg[ULC_PC_RTS_FLOW] ? rx_full : ~ctrl_reg[ULC_PC_RTS];

  // bus slave: one wait cycle, answer registered
  logic bus_req;
  assign bus_req = req.read | req.write;
  always_comb begin
    line_next  = line_reg;
    ctrl_next  = ctrl_reg;
    ibrd_next  = ibrd_reg;
    fbrd_next  = fbrd_reg;
    rdata_next = rdata_reg;
    ack_next   = bus_req & ~ack_reg;
    tx_push    = 1'b0;
    rx_pop     = 1'b0;
    if (bus_req && !ack_reg) begin
      rdata_next = 32'h0;
      unique case (req.address)
        ULC_ADDR_DATA: begin
          tx_push    = req.write & ~tx_full;
          rx_pop     = req.read & ~rx_empty;
          rdata_next = {22'h0, rx_fe_reg, rx_pe_reg, rxq[rx_rp_reg[QW-1:0]]};
        end
        ULC_ADDR_STAT: rdata_next = {24'h0, tx_empty, rx_full, tx_full, rx_empty,
                                     tx_st_reg != ULC_S_IDLE || !tx_empty, 2'b00, ~cts_n_eff};
        ULC_ADDR_IBRD: rdata_next = {16'h0, ibrd_reg};
        ULC_ADDR_FBRD: rdata_next = {26'h0, fbrd_reg};
        ULC_ADDR_LINE: rdata_next = {24'h0, line_reg};
        ULC_ADDR_CTRL: rdata_next = {16'h0, ctrl_reg};
        default:       rdata_next = 32'h0;
      endcase
      if (req.write) begin
        unique case (req.address)
          ULC_ADDR_IBRD: ibrd_next = req.writedata[15:0];
          ULC_ADDR_FBRD: fbrd_next = req.writedata[5:0];
          ULC_ADDR_LINE: line_next = req.writedata[7:0];
          // unimplemented bits stay zero whatever is written
          ULC_ADDR_CTRL: ctrl_next = req.writedata[15:0] & ULC_CTRL_WMASK;
          default: ;
        endcase
      end
    end
  end
  assign avs_waitrequest_out = bus_req & ~ack_reg;
  assign avs_readdata_out    = rdata_reg;

  // queue pointers; clearing queue enable drops transmit contents
  logic tx_flush;
  assign tx_flush = line_reg[ULC_LC_QUEUE] & ~line_next[ULC_LC_QUEUE];
  always_comb begin
    tx_wp_next = tx_wp_reg + (QW+1)'(tx_push);
    tx_rp_next = tx_rp_reg + (QW+1)'(tx_pop);
    if (tx_flush) begin
      tx_wp_next = '0;
      tx_rp_next = '0;
    end
    // a full receive queue drops the new word (overrun)
    rx_wp_next = rx_wp_reg + (QW+1)'(rx_push & ~rx_full);
    rx_rp_next = rx_rp_reg + (QW+1)'(rx_pop);
  end

  always_ff @(posedge clk_in) begin
    if (tx_push) txq[tx_wp_reg[QW-1:0]] <= req.writedata[7:0];
    if (rx_push && !rx_full) rxq[rx_wp_reg[QW-1:0]] <= rx_word;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_reg   <= ULC_LINE_RST;
      ctrl_reg   <= ULC_CTRL_RST;
      ibrd_reg   <= ULC_IBRD_RST;
      fbrd_reg   <= ULC_FBRD_RST;
      ack_reg    <= 1'b0;
      rdata_reg  <= 32'h0;
      bacc_reg   <= 22'h0;
      tx_wp_reg  <= '0;
      tx_rp_reg  <= '0;
      rx_wp_reg  <= '0;
      rx_rp_reg  <= '0;
      tx_st_reg  <= ULC_S_IDLE;
      tx_sub_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg  <= 8'h0;
      tx_par_reg <= 1'b0;
      tx_ln_reg  <= 1'b1;
      rx_st_reg  <= ULC_S_IDLE;
      rx_sub_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg  <= 8'h0;
      rx_pe_reg  <= 1'b0;
      rx_fe_reg  <= 1'b0;
    end else begin
      line_reg   <= line_next;
      ctrl_reg   <= ctrl_next;
      ibrd_reg   <= ibrd_next;
      fbrd_reg   <= fbrd_next;
      ack_reg    <= ack_next;
      rdata_reg  <= rdata_next;
      bacc_reg   <= bacc_next;
      tx_wp_reg  <= tx_wp_next;
      tx_rp_reg  <= tx_rp_next;
      rx_wp_reg  <= rx_wp_next;
      rx_rp_reg  <= rx_rp_next;
      tx_st_reg  <= tx_st_next;
      tx_sub_reg <= tx_sub_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg  <= tx_sh_next;
      tx_par_reg <= tx_par_next;
      tx_ln_reg  <= tx_ln_next;
      rx_st_reg  <= rx_st_next;
      rx_sub_reg <= rx_sub_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg  <= rx_sh_next;
      rx_pe_reg  <= rx_pe_next;
      rx_fe_reg  <= rx_fe_next;
    end
  end

  assign serial_out_line_out   = tx_ln_reg;
  assign request_to_send_n_out = rts_n;

  // checks
  a_start_needs_en: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tx_st_reg == ULC_S_IDLE && tx_st_next == ULC_S_START) |-> tx_go)
    else $error("frame started while transmit disabled");
  a_start_needs_cts: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tx_st_reg == ULC_S_IDLE && tx_st_next == ULC_S_START && ctrl_reg[ULC_PC_CTS_FLOW]) |-> !cts_n_eff)
    else $error("frame started without clear to send");
  a_rx_start_en: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rx_st_reg == ULC_S_IDLE && rx_st_next == ULC_S_START) |-> rx_go)
    else $error("reception started while disabled");
  a_rts_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctrl_reg[ULC_PC_RTS_FLOW] ? (request_to_send_n_out == rx_full)
                              : (request_to_send_n_out == !ctrl_reg[ULC_PC_RTS]))
    else $error("request to send output wrong");
  a_start_bit_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tx_st_reg == ULC_S_START) |-> !serial_out_line_out)
    else $error("start bit not low");
  a_idle_break: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tx_st_reg == ULC_S_IDLE && $past(tx_st_reg) == ULC_S_IDLE && $past(tick)
     && $past(line_reg[ULC_LC_HOLD_LOW]) && line_reg[ULC_LC_HOLD_LOW]) |-> !serial_out_line_out)
    else $error("break not held low");
  a_no_parity_state: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!line_reg[ULC_LC_PARITY] && tx_st_reg == ULC_S_DATA) |=> tx_st_reg != ULC_S_PARITY)
    else $error("parity bit sent while disabled");
  a_flush_tx: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    tx_flush |=> tx_empty)
    else $error("transmit queue not flushed");
  a_char_depth: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !line_reg[ULC_LC_QUEUE] |-> tx_cnt <= (QW+1)'(1))
    else $error("character mode holds more than one word");

endmodule

/* ulc_remote.sv */
`timescale 1ns/1ps
// far-side serial transceiver: samples our frames mid-bit and sends its own
module ulc_remote (
  // clock and frame settings
  input  wire logic        clk_in,
  input  wire logic [31:0] bit_clks_in,
  input  wire logic [3:0]  frame_bits_in,
  input  wire logic        hold_off_in,
  // serial lines
  input  wire logic        serial_line_in,
  output logic             serial_line_out,
  output logic             clear_to_send_n_out,
  // capture results
  output logic [11:0]      got_out,
  output int               count_out,
  output time              gap_out
);
  time last_start;

  // line idles high between frames, so nothing stale is left on it
  initial begin
    serial_line_out = 1'b1;
    count_out = 0;
    got_out = 12'h000;
    gap_out = 0;
    last_start = 0;
  end

  // handshake level is set by the bench acting for the far side
  assign clear_to_send_n_out = hold_off_in;

  // start found on the falling edge; each later bit sampled mid-cell
  always begin
    @(negedge serial_line_in);
    gap_out = $time - last_start;
    last_start = $time;
    repeat (bit_clks_in / 2) @(posedge clk_in);
    for (int i = 0; i < int'(frame_bits_in); i++) begin
      repeat (bit_clks_in) @(posedge clk_in);
      got_out[i] = serial_line_in;
    end
    count_out++;
  end

  // low start, bits lsb first, then back to idle high
  task automatic send(input logic [11:0] bits, input int n);
    @(posedge clk_in);
    serial_line_out <= 1'b0;
    repeat (bit_clks_in) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      serial_line_out <= bits[i];
      repeat (bit_clks_in) @(posedge clk_in);
    end
    serial_line_out <= 1'b1;
  endtask
endmodule

/* ulc_uart_tb.sv */
`timescale 1ns/1ps
module ulc_uart_tb;
  import ulc_pkg::*;
  localparam int BITC = 32; // divisor 2: two clocks a tick, sixteen ticks a bit
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b1; // driven low at time zero for a real falling edge
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata, q;
  logic        wreq, sin, sout, cts_n, rts_n;
  logic        hold_off = 1'b0;
  logic [11:0] got;
  logic [3:0]  fbits = 4'h9;
  int          nf, fails = 0, n_compared = 0;
  time         gap;

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  ulc_uart i_ulc_uart (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .serial_in_line_in(sin), .serial_out_line_out(sout), .clear_to_send_n_in(cts_n),
    .request_to_send_n_out(rts_n));
  ulc_remote i_ulc_remote (.clk_in(clk_in), .bit_clks_in(32'(BITC)), .frame_bits_in(fbits),
    .hold_off_in(hold_off), .serial_line_in(sout), .serial_line_out(sin), .clear_to_send_n_out(cts_n),
    .got_out(got), .count_out(nf), .gap_out(gap));

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk_in);
    while (wreq !== 1'b0 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 50) begin
      fails++;
      $display("CHECK FAILED at %0t: bus wait expired", $time);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_in);
  endtask

  // format changes only with the port off, then enable
  task automatic cfg(input logic [7:0] lc, input logic [15:0] pc);
    bus(ULC_ADDR_CTRL, 1'b1, {16'h0, pc & 16'hfffe});
    poll(32'h8, 32'h0);
    bus(ULC_ADDR_LINE, 1'b1, {24'h0, lc});
    bus(ULC_ADDR_CTRL, 1'b1, {16'h0, pc});
  endtask

  // bounded waits on frames, serial line and status bits
  task automatic wait_frames(input int k);
    int t0, n;
    t0 = nf;
    n = 0;
    while (nf < t0 + k && n < 4000) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 4000) begin
      fails++;
      $display("CHECK FAILED at %0t: frame wait expired", $time);
    end
  endtask

  task automatic wait_line(input logic v);
    int n;
    n = 0;
    while (sout !== v && n < 20 * BITC) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 20 * BITC) begin
      fails++;
      $display("CHECK FAILED at %0t: line wait expired", $time);
    end
  endtask

  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      bus(ULC_ADDR_STAT, 1'b0, 32'h0);
      n++;
    end while ((q & m) !== v && n < 200);
    if ((q & m) !== v) begin
      fails++;
      $display("CHECK FAILED at %0t: status poll expired", $time);
    end
  endtask

  // expected bits after the start bit; stops and unused slots are high
  function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] lc);
    int n;
    logic [11:0] f;
    logic p;
    n = 5 + int'(lc[6:5]);
    f = 12'hfff;
    for (int i = 0; i < n; i++) f[i] = d[i];
    p = lc[7] ? ~lc[2] : (^(d & 8'((9'h1 << n) - 1)) ^ ~lc[2]);
    if (lc[1]) f[n] = p;
    return f;
  endfunction

  task automatic t_reset();
    bus(ULC_ADDR_CTRL, 1'b0, 32'h0);
    check(q & 32'hc381, 32'h0300, "control reset");
    bus(ULC_ADDR_LINE, 1'b0, 32'h0);
    check(q, 32'h0, "line reset");
    check(32'(rts_n), 32'h1, "request idle");
    bus(4'hf, 1'b0, 32'h0);
    check(q, 32'h0, "unmapped read");
    bus(ULC_ADDR_IBRD, 1'b1, 32'h2);
    bus(ULC_ADDR_FBRD, 1'b1, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_queue();
    bus(ULC_ADDR_LINE, 1'b1, 32'h70);
    bus(ULC_ADDR_DATA, 1'b1, 32'h11);
    bus(ULC_ADDR_DATA, 1'b1, 32'h22);
    poll(32'h0, 32'h0);
    check(q & 32'ha0, 32'h0, "queue holds two");
    bus(ULC_ADDR_LINE, 1'b1, 32'h60);
    poll(32'h0, 32'h0);
    check(q & 32'ha0, 32'h80, "queue flushed");
    bus(ULC_ADDR_DATA, 1'b1, 32'h33);
    poll(32'h0, 32'h0);
    check(q & 32'ha0, 32'h20, "holding full");
    bus(ULC_ADDR_LINE, 1'b1, 32'h70);
    bus(ULC_ADDR_LINE, 1'b1, 32'h60);
    poll(32'h0, 32'h0);
    check(q & 32'ha0, 32'h80, "holding flushed");
    $display("queue test done");
  endtask

  task automatic t_formats();
    logic [7:0] lcs [5];
    int fb;
    logic [11:0] m;
    lcs = '{8'h94, 8'h32, 8'h5e, 8'hf2, 8'hf6};
    foreach (lcs[i]) begin
      cfg(lcs[i], 16'h0301);
      fb = 6 + int'(lcs[i][6:5]) + int'(lcs[i][1]) + int'(lcs[i][3]);
      fbits <= 4'(fb);
      m = 12'((13'h1 << fb) - 1);
      bus(ULC_ADDR_DATA, 1'b1, 32'h5c);
      bus(ULC_ADDR_DATA, 1'b1, 32'ha6);
      wait_frames(2);
      check(32'(got & m), 32'(frame(8'ha6, lcs[i]) & m), "frame");
      check(32'(gap), 32'((fb + 1) * BITC * 10), "frame length");
    end
    $display("format test done");
  endtask

  task automatic t_enable();
    int c;
    fbits <= 4'h9;
    cfg(8'h70, 16'h0201);
    c = nf;
    bus(ULC_ADDR_DATA, 1'b1, 32'h3c);
    repeat (12 * BITC) @(posedge clk_in);
    check(32'(nf), 32'(c), "sent while transmit off");
    bus(ULC_ADDR_CTRL, 1'b1, 32'h0301);
    wait_frames(1);
    check(32'(got[8:0]), 32'h13c, "held byte");
    bus(ULC_ADDR_DATA, 1'b1, 32'hc3);
    wait_line(1'b0);
    bus(ULC_ADDR_CTRL, 1'b1, 32'h0300);
    wait_frames(1);
    check(32'(got[8:0]), 32'h1c3, "frame after disable");
    cfg(8'h70, 16'h0101);
    i_ulc_remote.send(12'h15a, 9);
    poll(32'h10, 32'h10);
    check(q & 32'h10, 32'h10, "received while off");
    $display("enable test done");
  endtask

  task automatic t_flow();
    int c;
    hold_off <= 1'b1;
    cfg(8'h70, 16'h8301);
    c = nf;
    bus(ULC_ADDR_DATA, 1'b1, 32'h81);
    repeat (12 * BITC) @(posedge clk_in);
    check(32'(nf), 32'(c), "sent while held off");
    hold_off <= 1'b0;
    wait_frames(1);
    check(32'(got[8:0]), 32'h181, "frame after clear");
    cfg(8'h60, 16'h0a01);
    check(32'(rts_n), 32'h0, "request bit set");
    bus(ULC_ADDR_CTRL, 1'b1, 32'h0201);
    check(32'(rts_n), 32'h1, "request bit clear");
    bus(ULC_ADDR_CTRL, 1'b1, 32'h4a01);
    check(32'(rts_n), 32'h0, "request with room");
    i_ulc_remote.send(12'h155, 9);
    poll(32'h10, 32'h0);
    check(32'(rts_n), 32'h1, "request when full");
    bus(ULC_ADDR_DATA, 1'b0, 32'h0);
    check(32'(rts_n), 32'h0, "request after read");
    $display("flow test done");
  endtask

  task automatic t_break();
    cfg(8'h71, 16'h0301);
    wait_line(1'b0);
    repeat (2 * BITC) @(posedge clk_in);
    check(32'(sout), 32'h0, "line held low");
    cfg(8'h70, 16'h0301);
    wait_line(1'b1);
    check(32'(sout), 32'h1, "line released");
    repeat (12 * BITC) @(posedge clk_in);
    $display("break test done");
  endtask

  task automatic t_loop();
    hold_off <= 1'b1;
    cfg(8'h70, 16'h0b81);
    bus(ULC_ADDR_DATA, 1'b1, 32'h96);
    poll(32'h10, 32'h0);
    bus(ULC_ADDR_DATA, 1'b0, 32'h0);
    check(q & 32'h3ff, 32'h096, "looped byte");
    poll(32'h0, 32'h0);
    check(q & 32'h1, 32'h1, "looped handshake");
    hold_off <= 1'b0;
    $display("loopback test done");
  endtask

  // last: the missing second stop leaves a stray word behind
  task automatic t_rx();
    logic [7:0]  lcs [4];
    logic [11:0] bits [4];
    logic [31:0] exp [4];
    lcs = '{8'h76, 8'h76, 8'hf2, 8'h7e};
    bits = '{12'h25a, 12'h35a, 12'h25a, 12'h25a};
    exp = '{32'h05a, 32'h15a, 32'h15a, 32'h05a};
    foreach (lcs[i]) begin
      cfg(lcs[i], 16'h0201);
      i_ulc_remote.send(bits[i], 10 + int'(lcs[i][3]));
      poll(32'h10, 32'h0);
      bus(ULC_ADDR_DATA, 1'b0, 32'h0);
      check(q & 32'h3ff, exp[i], "received word");
    end
    $display("receive test done");
  endtask

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // main sequence after five reset cycles
  initial begin
    rst_n_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_queue();
    t_formats();
    t_enable();
    t_flow();
    t_break();
    t_loop();
    t_rx();
    print_verdict();
  end

  // watchdog well past the expected run of under 10k clocks
  initial begin
    #600000;
    fails++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
